// ==== rtl/ldh_header.sv ====
// configuration header of a non-bridging chain device
// assumes config requests arrive with device and function number still to be matched here,
// all inputs synchronous to mclk, rst_b is the cold reset;
// every output is registered, one cycle behind what caused it
`timescale 1ns/10ps
`default_nettype none

// How it works
// - i/o requests need command bit 0
// - memory requests need command bit 1
// - subtractive decode takes compat requests always
// - own requests need bit 2, forwarding free
// - bit 8 set floods sync on error
// - bit 8 clear: only init, forwarded sync or a flood already latched
// - unlisted command and status bits read zero
// - status bit 4 always reads one
// - bit 11 set on sent target abort
// - bits 12, 13 set on received aborts
// - bit 14 only for own sync flood
// - abort flags clear by writing one
// - cache line and latency bytes read zero
// - window bit 0 gives space, warm reset
// - size bits hardwired zero
// - memory base zero-extended to 40 bits
// - i/o compare 25 bits, top bits zero
// - i/o windows aligned on 64 bytes
// - absent device number: error plus nonexistent flag
module ldh_header (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        warm_rst_b,
  input  wire logic [4:0]  base_unit_id,
  // configuration requests from the host bridge
  input  wire logic        cfg_req,
  input  wire logic        cfg_wr,
  input  wire logic [4:0]  cfg_dev_num,
  input  wire logic [2:0]  cfg_func_num,
  input  wire logic [5:0]  cfg_reg_num,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_err,
  output logic             nonexistent_address_flag,
  // incoming memory and i/o requests
  input  wire logic        req_valid,
  input  wire logic        req_io,
  input  wire logic        req_compat,
  input  wire logic [39:0] req_addr,
  output logic             req_accept,
  output logic             req_reject,
  // own requests toward the chain
  input  wire logic        own_req,
  output logic             own_req_grant,
  // response and error events
  input  wire logic        tgt_abort_sent,
  input  wire logic        rsp_tgt_abort,
  input  wire logic        rsp_mst_abort,
  input  wire logic        flood_error,
  input  wire logic        link_init,
  input  wire logic [1:0]  sync_in,
  output logic [1:0]       sync_out
);
  ldh_cfg_if cfg_bus ();

  // state
  logic        io_en_reg;
  logic        mem_en_reg;
  logic        bm_en_reg;
  logic        serr_en_reg;
  logic        flood_reg;
  logic        cfg_ack_reg;
  logic [31:0] cfg_rdata_reg;
  logic        cfg_err_reg;
  logic        nonexist_reg;
  logic        accept_reg;
  logic        reject_reg;
  logic        grant_reg;
  logic [1:0]  sync_reg;

  // next values and decode
  logic        warm;
  logic        dev_hit;
  logic        cfg_take;
  logic        cfg_wr_hit;
  logic [7:0]  cfg_off;
  logic [31:0] cmd_dw;
  logic [31:0] cmd_merged;
  logic [15:0] cmd_val;
  logic [15:0] stat_val;
  logic [31:0] rd_mux;
  logic [31:0] bar0_val;
  logic [31:0] bar1_val;
  logic        bar0_hit;
  logic        bar1_hit;
  logic [3:0]  flag_set;
  logic [3:0]  flags;
  logic        mem_ok;
  logic        io_ok;
  logic        compat_ok;
  logic        accept_next;
  logic        flood_start;
  logic        flood_next;
  logic [1:0]  sync_next;
  logic        sel_id;
  logic        sel_cmd;
  logic        sel_bar0;
  logic        sel_bar1;
  logic        cmd_wr_hit;
  logic [31:0] rdata_next;
  logic        absent_next;
  logic        reject_next;
  logic        grant_next;

  // warm reset also fires during cold reset
  assign warm = !rst_b || !warm_rst_b;

  // only function 0 at the base unit id exists
  assign dev_hit  = (cfg_dev_num == base_unit_id) && (cfg_func_num == 3'h0);
  assign cfg_take = cfg_req && dev_hit;
  assign cfg_off  = {cfg_reg_num, 2'b00};
  assign cfg_wr_hit = cfg_take && cfg_wr;

  // carrier toward the window and status sub-blocks
  assign cfg_bus.wr    = cfg_wr_hit;
  assign cfg_bus.off   = cfg_off;
  assign cfg_bus.wdata = cfg_wdata;
  assign cfg_bus.be    = cfg_be;
  assign cfg_bus.warm  = warm;

  // command readback: only four bits exist, rest zero
  assign cmd_val = {7'h00, serr_en_reg, 5'h00, bm_en_reg,
                    mem_en_reg, io_en_reg};
  // status: capability bit tied high, four sticky flags
  assign stat_val = {1'b0, flags, 6'h00, 1'b1, 4'h0};
  assign cmd_dw = {stat_val, cmd_val};
  assign cmd_merged = ldh_pkg::be_merge(cmd_dw, cfg_wdata, cfg_be);

  // dword selects, shared by the read mux and the command write
  assign sel_id     = (cfg_off == ldh_pkg::OFF_ID);
  assign sel_cmd    = (cfg_off == ldh_pkg::OFF_CMD);
  assign sel_bar0   = (cfg_off == ldh_pkg::OFF_BAR0);
  assign sel_bar1   = (cfg_off == ldh_pkg::OFF_BAR1);
  assign cmd_wr_hit = cfg_wr_hit && sel_cmd;

  // read mux by dword; the cache line and latency dword reads zero,
  // header type zero marks a device header; any offset not listed
  // falls through to zero, which keeps unused window slots sizeless
  assign rd_mux =
    sel_id   ? {ldh_pkg::DEVICE_ID, ldh_pkg::VENDOR_ID} :
    sel_cmd  ? cmd_dw :
    sel_bar0 ? bar0_val :
    sel_bar1 ? bar1_val :
    32'h0000_0000;

  // command bits, cleared by warm and cold reset; a write with the
  // low lanes off keeps them, so status clears leave the enables alone
  always_ff @(posedge mclk) begin
    if (warm) begin
      io_en_reg   <= ldh_pkg::CMD_RST;
      mem_en_reg  <= ldh_pkg::CMD_RST;
      bm_en_reg   <= ldh_pkg::CMD_RST;
      serr_en_reg <= ldh_pkg::CMD_RST;
    end else if (cmd_wr_hit) begin
      io_en_reg   <= cmd_merged[ldh_pkg::CMD_IO_EN];
      mem_en_reg  <= cmd_merged[ldh_pkg::CMD_MEM_EN];
      bm_en_reg   <= cmd_merged[ldh_pkg::CMD_BM_EN];
      serr_en_reg <= cmd_merged[ldh_pkg::CMD_SERR_EN];
    end
  end

  // the two windows: a 4 Kbyte memory one and a 64-byte i/o one;
  // other window slots read zero and so size to nothing
  ldh_bar #(
    .OFFSET (ldh_pkg::OFF_BAR0),
    .IS_IO  (1'b0),
    .LSB    (ldh_pkg::MEM_LSB)
  ) u_bar_mem (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .cfg    (cfg_bus.dst),
    .addr   (req_addr),
    .rd_val (bar0_val),
    .hit    (bar0_hit)
  );

  ldh_bar #(
    .OFFSET (ldh_pkg::OFF_BAR1),
    .IS_IO  (1'b1),
    .LSB    (ldh_pkg::IO_LSB)
  ) u_bar_io (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .cfg    (cfg_bus.dst),
    .addr   (req_addr),
    .rd_val (bar1_val),
    .hit    (bar1_hit)
  );

  // sticky flags, order: sent target abort, received target abort,
  // received master abort, signaled system error
  assign flag_set = {flood_start, rsp_mst_abort, rsp_tgt_abort,
                     tgt_abort_sent};

  ldh_stat u_stat (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cfg   (cfg_bus.dst),
    .set   (flag_set),
    .flag  (flags)
  );

  // answer contents; writes and absent targets return zero data so
  // nothing stale leaks onto the response
  assign rdata_next  = (cfg_take && !cfg_wr) ? rd_mux : 32'h0000_0000;
  assign absent_next = cfg_req && !dev_hit;

  // configuration answer one cycle after the request; a missing
  // device number still gets an answer so the host never hangs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_ack_reg   <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
      cfg_err_reg   <= 1'b0;
      nonexist_reg  <= 1'b0;
    end else begin
      cfg_ack_reg   <= cfg_req;
      cfg_rdata_reg <= rdata_next;
      cfg_err_reg   <= absent_next;
      nonexist_reg  <= absent_next;
    end
  end

  // address decode; windows are trusted only after firmware set them
  // up, since the enables stay low until then
  assign mem_ok    = !req_io && mem_en_reg && bar0_hit;
  assign io_ok     = req_io && io_en_reg && bar1_hit;
  assign compat_ok = req_compat && ldh_pkg::SUBTRACTIVE;
  assign accept_next = req_valid && (compat_ok || mem_ok || io_ok);
  assign reject_next = req_valid && !accept_next;

  // exactly one of accept or reject per request, never both
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      accept_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      accept_reg <= accept_next;
      reject_reg <= reject_next;
    end
  end

  // own requests are gated; forwarded traffic never passes here
  assign grant_next = own_req && bm_en_reg;

  // a warm reset drops the enable, so the grant falls a cycle later
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      grant_reg <= 1'b0;
    end else begin
      grant_reg <= grant_next;
    end
  end

  // flood starts only when enabled; it lasts until a reset because
  // the flooded link can no longer carry configuration writes
  assign flood_start = flood_error && serr_en_reg && !flood_reg;
  assign flood_next  = flood_reg || flood_start;

  // each outgoing link: own flood, link init, or the other link's sync
  assign sync_next[0] = flood_next || link_init || sync_in[1];
  assign sync_next[1] = flood_next || link_init || sync_in[0];

  // flood latch; a warm reset is the only way out short of cold
  always_ff @(posedge mclk) begin
    if (warm) begin
      flood_reg <= 1'b0;
    end else begin
      flood_reg <= flood_next;
    end
  end

  // link sync drivers, silent during either reset
  always_ff @(posedge mclk) begin
    if (warm) begin
      sync_reg <= 2'b00;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // all outputs straight from flops
  assign cfg_ack                  = cfg_ack_reg;
  assign cfg_rdata                = cfg_rdata_reg;
  assign cfg_err                  = cfg_err_reg;
  assign nonexistent_address_flag = nonexist_reg;
  assign req_accept               = accept_reg;
  assign req_reject               = reject_reg;
  assign own_req_grant            = grant_reg;
  assign sync_out                 = sync_reg;
endmodule : ldh_header
`default_nettype wire

// ==== rtl/ldh_pkg.sv ====
// constants for the chain device configuration header
// assumes one function, two implemented base address windows
package ldh_pkg;
  // byte offsets inside the header
  localparam logic [7:0] OFF_ID      = 8'h00;
  localparam logic [7:0] OFF_CMD     = 8'h04;
  localparam logic [7:0] OFF_STAT    = 8'h06;
  localparam logic [7:0] OFF_CLS     = 8'h0c;
  localparam logic [7:0] OFF_LAT     = 8'h0d;
  localparam logic [7:0] OFF_BAR0    = 8'h10;
  localparam logic [7:0] OFF_BAR1    = 8'h14;
  // command field positions
  localparam int CMD_IO_EN   = 0;
  localparam int CMD_MEM_EN  = 1;
  localparam int CMD_BM_EN   = 2;
  localparam int CMD_SERR_EN = 8;
  // status field positions
  localparam int STAT_CAP    = 4;
  localparam int STAT_STA    = 11;
  localparam int STAT_RTA    = 12;
  localparam int STAT_RMA    = 13;
  localparam int STAT_SSE    = 14;
  localparam int STAT_NFLAG  = 4;
  // window shapes: first writeable base bit
  localparam int MEM_LSB     = 12;   // 4 Kbyte memory window
  localparam int IO_LSB      = 6;    // 64-byte aligned i/o window
  localparam int IO_ABITS    = 25;
  localparam int ADDR_W      = 40;
  // reset values and fixed feature switches
  localparam logic        CMD_RST  = 1'b0;
  localparam logic        FLAG_RST = 1'b0;
  localparam logic        SUBTRACTIVE = 1'b1;
  localparam logic        MEM_PREFETCH = 1'b0;
  // identity, values arbitrary
  localparam logic [15:0] VENDOR_ID = 16'h1234;
  localparam logic [15:0] DEVICE_ID = 16'h5678;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge
endpackage : ldh_pkg

// ==== rtl/ldh_cfg_if.sv ====
// configuration write carrier between the header and its sub-blocks
// assumes all parties run on mclk
`timescale 1ns/10ps
`default_nettype none
interface ldh_cfg_if;
  logic        wr;      // one-cycle write strobe, already decoded
  logic [7:0]  off;     // byte offset of the dword
  logic [31:0] wdata;
  logic [3:0]  be;
  logic        warm;    // warm or cold reset in progress
  modport src (output wr, output off, output wdata, output be, output warm);
  modport dst (input wr, input off, input wdata, input be, input warm);
endinterface : ldh_cfg_if
`default_nettype wire

// ==== rtl/ldh_bar.sv ====
// one base address window: storage, readback and address match
// assumes writes arrive decoded on the carrier, reset is synchronous
`timescale 1ns/10ps
`default_nettype none
module ldh_bar #(
  parameter logic [7:0] OFFSET = 8'h10,
  parameter bit         IS_IO  = 1'b0,
  parameter int         LSB    = 12
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  ldh_cfg_if.dst                       cfg,
  input  wire logic [ldh_pkg::ADDR_W-1:0] addr,
  output logic [31:0]                  rd_val,
  output logic                         hit
);
  logic [31:LSB] base_reg;
  logic [31:0]   merged;
  logic [31:0]   low_bits;

  // size bits read zero so sizing sees the window size
  assign merged = ldh_pkg::be_merge(rd_val, cfg.wdata, cfg.be);
  // bit 0 space type, bits 2:1 memory type zero, bit 3 prefetchable
  assign low_bits = IS_IO ? 32'h0000_0001
                          : {28'h000_0000, ldh_pkg::MEM_PREFETCH, 3'h0};
  assign rd_val = {base_reg, low_bits[LSB-1:0]};

  // base cleared by warm and cold reset
  always_ff @(posedge mclk) begin
    if (!rst_b || cfg.warm) begin
      base_reg <= '0;
    end else if (cfg.wr && cfg.off == OFFSET) begin
      base_reg <= merged[31:LSB];
    end
  end

  // i/o space is only 25 bits wide; memory base zero-extended to 40
  generate
    if (IS_IO) begin : g_io
      assign hit = (addr[ldh_pkg::IO_ABITS-1:LSB] == base_reg[ldh_pkg::IO_ABITS-1:LSB])
                   && (base_reg[31:26] == 6'h00);
    end else begin : g_mem
      assign hit = (addr[ldh_pkg::ADDR_W-1:LSB] == {8'h00, base_reg});
    end
  endgenerate
endmodule : ldh_bar
`default_nettype wire

// ==== rtl/ldh_stat.sv ====
// sticky status flags, write one to clear, cold reset only
// assumes set pulses are one cycle wide and synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module ldh_stat (
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  ldh_cfg_if.dst                             cfg,
  input  wire logic [ldh_pkg::STAT_NFLAG-1:0] set,
  output logic [ldh_pkg::STAT_NFLAG-1:0]     flag
);
  logic                               clr_hit;
  logic [ldh_pkg::STAT_NFLAG-1:0]     clr;

  // the status flag bits live in byte 3 of the dword
  assign clr_hit = cfg.wr && cfg.off == ldh_pkg::OFF_CMD && cfg.be[3];
  assign clr = clr_hit ? cfg.wdata[16+ldh_pkg::STAT_STA +: ldh_pkg::STAT_NFLAG] : '0;

  // set wins over a clear in the same cycle so no event is lost
  generate
    for (genvar i = 0; i < ldh_pkg::STAT_NFLAG; i++) begin : g_flag
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          flag[i] <= ldh_pkg::FLAG_RST;
        end else if (set[i]) begin
          flag[i] <= 1'b1;
        end else if (clr[i]) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : ldh_stat
`default_nettype wire

// ==== sim/ldh_header_chk.sv ====
// port-level assertions for the chain device configuration header
// assumes it is bound to ldh_header and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module ldh_header_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        warm_rst_b,
  input wire logic [4:0]  base_unit_id,
  input wire logic        cfg_req,
  input wire logic        cfg_wr,
  input wire logic [4:0]  cfg_dev_num,
  input wire logic [2:0]  cfg_func_num,
  input wire logic [5:0]  cfg_reg_num,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_err,
  input wire logic        nonexistent_address_flag,
  input wire logic        req_valid,
  input wire logic        req_compat,
  input wire logic        req_accept,
  input wire logic        req_reject,
  input wire logic        own_req,
  input wire logic        own_req_grant,
  input wire logic        link_init,
  input wire logic [1:0]  sync_out
);
  // both resets silence the checks; cold reset forces the outputs low, warm reset only sync_out
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b || !warm_rst_b);
  // read aimed at this function, dword n
  sequence s_rd(int n);
    cfg_req && !cfg_wr && cfg_dev_num == base_unit_id && cfg_func_num == 3'h0
      && cfg_reg_num == n;
  endsequence
  sequence s_absent;
    cfg_req && (cfg_dev_num != base_unit_id || cfg_func_num != 3'h0);
  endsequence
  a_ack_one_cycle: assert property (cfg_ack == $past(cfg_req))
    else $error("ack not one cycle after request");
  a_absent_dev_err: assert property (s_absent |=> cfg_err && nonexistent_address_flag)
    else $error("absent device not answered with error");
  a_cmd_stat_mask: assert property (s_rd(1) |=> (cfg_rdata & 32'h87effef8) == 32'h0)
    else $error("unimplemented command or status bit set");
  a_cap_bit_one: assert property (s_rd(1) |=> cfg_rdata[20] && !cfg_err)
    else $error("capabilities bit not one");
  a_cls_lat_zero: assert property (s_rd(3) |=> cfg_rdata[15:0] == 16'h0)
    else $error("cache line or latency byte not zero");
  a_mem_win_low: assert property (s_rd(4) |=> cfg_rdata[11:0] == 12'h0)
    else $error("memory window low bits not zero");
  a_io_win_low: assert property (s_rd(5) |=> cfg_rdata[5:0] == 6'h01)
    else $error("io window low bits wrong");
  a_compat_taken: assert property (req_valid && req_compat |=> req_accept && !req_reject)
    else $error("compat request not accepted");
  a_one_answer: assert property (req_valid |=> req_accept ^ req_reject)
    else $error("request needs exactly one answer");
  a_grant_needs_req: assert property (!own_req |=> !own_req_grant)
    else $error("grant without own request");
  a_init_sync: assert property (link_init |=> sync_out == 2'b11)
    else $error("no sync during link init");
endmodule : ldh_header_chk
bind ldh_header ldh_header_chk u_ldh_header_chk (
  .mclk(mclk), .rst_b(rst_b), .warm_rst_b(warm_rst_b), .base_unit_id(base_unit_id),
  .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_dev_num(cfg_dev_num),
  .cfg_func_num(cfg_func_num), .cfg_reg_num(cfg_reg_num), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .cfg_err(cfg_err),
  .nonexistent_address_flag(nonexistent_address_flag), .req_valid(req_valid),
  .req_compat(req_compat), .req_accept(req_accept), .req_reject(req_reject),
  .own_req(own_req), .own_req_grant(own_req_grant), .link_init(link_init),
  .sync_out(sync_out));
`default_nettype wire

// ==== sim/ldh_host.sv ====
// host bridge model issuing configuration requests
// assumes the bench calls xfer only after reset has been released
`timescale 1ns/10ps
`default_nettype none
module ldh_host (
  input  wire logic        mclk,
  output logic             cfg_req,
  output logic             cfg_wr,
  output logic [4:0]       cfg_dev_num,
  output logic [2:0]       cfg_func_num,
  output logic [5:0]       cfg_reg_num,
  output logic [31:0]      cfg_wdata,
  output logic [3:0]       cfg_be,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_err,
  input  wire logic        nonexistent_address_flag
);
  initial begin
    {cfg_req, cfg_wr, cfg_dev_num, cfg_func_num, cfg_reg_num, cfg_wdata, cfg_be} = '0;
  end
  // one request per call, answer taken when the request drops
  task automatic xfer(input logic w, input logic [4:0] dev, input logic [2:0] fn,
                      input logic [5:0] r, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] rd, output logic [1:0] e, output logic a);
    @(negedge mclk);
    cfg_req = 1'b1;
    cfg_wr = w;
    cfg_dev_num = dev;
    cfg_func_num = fn;
    cfg_reg_num = r;
    cfg_wdata = d;
    cfg_be = be;
    @(negedge mclk);
    a = cfg_ack;
    rd = cfg_rdata;
    e = {cfg_err, nonexistent_address_flag};
    cfg_req = 1'b0;
    cfg_wdata = ~cfg_wdata; // stale data must not look valid
  endtask : xfer
endmodule : ldh_host
`default_nettype wire

// ==== sim/link_device_config_header_bench.sv ====
// self-checking bench for the chain device configuration header
// assumes ldh_header, ldh_host and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module link_device_config_header_bench;
  localparam logic [4:0] UID = 5'h03;
  logic mclk = 1'b0, rst_b = 1'b0, warm_rst_b = 1'b1;
  logic cfg_req, cfg_wr, cfg_ack, cfg_err, ne_flag;
  logic [4:0] cfg_dev_num;
  logic [2:0] cfg_func_num, ev = '0;
  logic [5:0] cfg_reg_num;
  logic [31:0] cfg_wdata, cfg_rdata, b0, b1, c, rdv;
  logic [3:0] cfg_be;
  logic req_valid = 0, req_io = 0, req_compat = 0, own_req = 0, flood = 0, link_init = 0;
  logic [39:0] req_addr = '0, a;
  logic [63:0] r64;
  logic [1:0] sync_in = '0, sync_out, e;
  logic req_accept, req_reject, own_req_grant, ak;
  int miscompares = 0, check_count = 0;
  always #20 mclk = ~mclk;
  ldh_host u_ldh_host (.mclk(mclk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_dev_num(cfg_dev_num), .cfg_func_num(cfg_func_num), .cfg_reg_num(cfg_reg_num),
    .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .cfg_err(cfg_err), .nonexistent_address_flag(ne_flag));
  ldh_header u_ldh_header (.mclk(mclk), .rst_b(rst_b), .warm_rst_b(warm_rst_b),
    .base_unit_id(UID), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_dev_num(cfg_dev_num),
    .cfg_func_num(cfg_func_num), .cfg_reg_num(cfg_reg_num), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_err(cfg_err),
    .nonexistent_address_flag(ne_flag), .req_valid(req_valid), .req_io(req_io),
    .req_compat(req_compat), .req_addr(req_addr), .req_accept(req_accept),
    .req_reject(req_reject), .own_req(own_req), .own_req_grant(own_req_grant),
    .tgt_abort_sent(ev[0]), .rsp_tgt_abort(ev[1]), .rsp_mst_abort(ev[2]),
    .flood_error(flood), .link_init(link_init), .sync_in(sync_in), .sync_out(sync_out));
  task automatic wr(input logic [5:0] r, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] x;
    u_ldh_host.xfer(1'b1, UID, 3'h0, r, d, be, x, e, ak);
    `CHK({ak, e}, 3'b100)
  endtask : wr
  task automatic chk_rd(input logic [5:0] r, input logic [31:0] want);
    u_ldh_host.xfer(1'b0, UID, 3'h0, r, 32'h0, 4'hf, rdv, e, ak);
    `CHK({ak, e, rdv}, {3'b100, want})
  endtask : chk_rd
  task automatic req(input logic io, input logic cp, input logic [39:0] ad, input logic x);
    @(negedge mclk);
    {req_valid, req_io, req_compat, req_addr} = {1'b1, io, cp, ad};
    @(negedge mclk);
    req_valid = 1'b0;
    req_addr = ~ad;
    `CHK({req_accept, req_reject}, {x, ~x})
  endtask : req
  // claim expected from enables, window bases and the compat flag
  function automatic logic hit(input logic [31:0] cm, input logic io, input logic cp);
    if (cp) return 1'b1;
    if (io) return cm[0] && a[24:6] == b1[24:6] && b1[31:26] == 6'h0;
    return cm[1] && a[39:12] == {8'h0, b0[31:12]};
  endfunction : hit
  task automatic pulse_flood();
    @(negedge mclk) flood = 1'b1;
    @(negedge mclk) flood = 1'b0;
  endtask : pulse_flood
  task conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // watchdog at 20000 cycles, far above the under one thousand cycles the run needs
  initial begin
    #(40 * 20000);
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(32'hc2e6));
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    chk_rd(1, 32'h00100000);
    chk_rd(4, 32'h0);
    chk_rd(5, 32'h1);
    chk_rd(9, 32'h0);
    wr(1, 32'hffffffff, 4'hf);
    chk_rd(1, 32'h00100107);
    wr(3, 32'hffffffff, 4'hf);
    chk_rd(3, 32'h0);
    wr(4, 32'hffffffff, 4'hf);
    chk_rd(4, 32'hfffff000);
    wr(5, 32'hffffffff, 4'hf);
    chk_rd(5, 32'hffffffc1);
    for (int i = 0; i < 4; i++) begin
      u_ldh_host.xfer(1'b0, UID ^ i[4:0], i[2:0], 6'h1, 32'h0, 4'hf, rdv, e, ak);
      `CHK({ak, e}, {1'b1, i != 0, i != 0})
    end
    // random windows, enables and addresses, with hits forced often
    for (int i = 0; i < 80; i++) begin
      c = $urandom;
      b0 = $urandom & 32'hfffff000;
      b1 = ($urandom & 32'hffffffc0) | 32'h1;
      if (c[4]) b1[31:26] = 6'h0;
      wr(1, 32'h0, 4'h3);
      wr(4, b0, 4'hf);
      wr(5, b1, 4'hf);
      wr(1, {29'h0, c[2:0]}, 4'h3);
      r64 = {$urandom, $urandom};
      a = r64[39:0];
      if (c[5]) a[39:12] = {8'h0, b0[31:12]};
      if (c[6]) a[24:6] = b1[24:6];
      own_req = c[10];
      req(c[7], c[8] & c[9], a, hit(c, c[7], c[8] & c[9]));
      `CHK(own_req_grant, c[10] & c[2])
    end
    own_req = 1'b0;
    wr(1, 32'h0, 4'h3);
    for (int k = 0; k < 3; k++) begin
      @(negedge mclk) ev = 3'b001 << k;
      @(negedge mclk) ev = 3'b000;
      chk_rd(1, {16'h0010 | (16'h0800 << k), 16'h0});
      wr(1, 32'h0, 4'h8);
      chk_rd(1, {16'h0010 | (16'h0800 << k), 16'h0});
      wr(1, 32'h08000000 << k, 4'h8);
      chk_rd(1, 32'h00100000);
    end
    pulse_flood();
    `CHK(sync_out, 2'b00)
    sync_in = 2'b01;
    @(negedge mclk) sync_in = 2'b00;
    `CHK(sync_out, 2'b10)
    @(negedge mclk) sync_in = 2'b10;
    @(negedge mclk) sync_in = 2'b00;
    `CHK(sync_out, 2'b01)
    chk_rd(1, 32'h00100000);
    link_init = 1'b1;
    @(negedge mclk) link_init = 1'b0;
    `CHK(sync_out, 2'b11)
    wr(1, 32'h00000100, 4'h3);
    pulse_flood();
    repeat (3) @(negedge mclk);
    `CHK(sync_out, 2'b11)
    chk_rd(1, 32'h40100100);
    wr(4, 32'h00042000, 4'hf);
    @(negedge mclk) warm_rst_b = 1'b0;
    @(negedge mclk) warm_rst_b = 1'b1;
    `CHK(sync_out, 2'b00)
    chk_rd(1, 32'h40100000);
    chk_rd(4, 32'h0);
    @(negedge mclk) rst_b = 1'b0;
    @(negedge mclk) rst_b = 1'b1;
    chk_rd(1, 32'h00100000);
    conclude();
  end
endmodule : link_device_config_header_bench
`default_nettype wire
